// >>> npsr_regs.sv
// oscillator phase-sync control and channel A preset-0 registers
//
// Local design decision: register access over Avalon-MM.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module npsr_regs #(
  parameter int PHASE_BITS = 16
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic [13:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output var logic [31:0] AVS_READDATA,
  output var logic AVS_WAITREQUEST,
  input wire logic SYNC_N,
  input wire logic SYSREF,
  input wire logic FRAME_BOUNDARY,
  output var logic PHASE_INIT,
  output var logic OSC_ACTIVE,
  output var logic [31:0] OSC_FREQ,
  output var logic [31:0] OSC_PHASE,
  output var logic LINK_SYNC_REQ
);
  if (PHASE_BITS != npsr_pkg::PHASE_W) begin : g_chk
    $error("PHASE_BITS must equal 16");
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, answer on the second edge
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [7:0] sync_ctrl_ff, nxt_sync_ctrl;
  logic [31:0] freq_ff, nxt_freq;
  logic [15:0] phase_ff, nxt_phase;
  logic [7:0] link_ctrl_ff, nxt_link_ctrl;
  logic arm_wr_ff, nxt_arm_wr;
  logic arm_val_ff, nxt_arm_val;
  logic [11:0] idx;
  logic wr_go, rd_go;
  npsr_pkg::npsr_arm_t arm_ff, nxt_arm;
  logic link_pend_ff, nxt_link_pend;

  assign idx = AVS_ADDRESS[13:2];
  assign wr_go = AVS_WRITE && !ack_ff;
  assign rd_go = AVS_READ && !ack_ff;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [31:0] m;
    m = 32'h00000000;
    nxt_ack = (AVS_READ || AVS_WRITE) && !ack_ff;
    nxt_rdata = rdata_ff;
    nxt_sync_ctrl = sync_ctrl_ff;
    nxt_freq = freq_ff;
    nxt_phase = phase_ff;
    nxt_link_ctrl = link_ctrl_ff;
    nxt_arm_wr = 1'b0;
    nxt_arm_val = arm_val_ff;
    if (wr_go) begin
      case (idx)
        npsr_pkg::IDX_SYNC_CTRL: begin
          m = merge({24'h000000, sync_ctrl_ff}, AVS_WRITEDATA, AVS_BYTEENABLE);
          nxt_sync_ctrl = m[7:0];
          nxt_arm_wr = AVS_BYTEENABLE[0];
          nxt_arm_val = AVS_WRITEDATA[npsr_pkg::POS_ARM];
        end
        npsr_pkg::IDX_FREQ_A0: begin
          nxt_freq = merge(freq_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
        end
        npsr_pkg::IDX_PHASE_A0: begin
          m = merge({16'h0000, phase_ff}, AVS_WRITEDATA, AVS_BYTEENABLE);
          nxt_phase = m[15:0];
        end
        npsr_pkg::IDX_LINK_CTRL: begin
          m = merge({24'h000000, link_ctrl_ff}, AVS_WRITEDATA, AVS_BYTEENABLE);
          nxt_link_ctrl = m[7:0];
        end
        default: begin
          nxt_link_ctrl = link_ctrl_ff;
        end
      endcase
    end
    if (rd_go) begin
      case (idx)
        npsr_pkg::IDX_SYNC_CTRL: nxt_rdata = {24'h000000, sync_ctrl_ff};
        npsr_pkg::IDX_FREQ_A0: nxt_rdata = freq_ff;
        npsr_pkg::IDX_PHASE_A0: nxt_rdata = {16'h0000, phase_ff};
        npsr_pkg::IDX_LINK_CTRL: nxt_rdata = {24'h000000, link_ctrl_ff};
        npsr_pkg::IDX_STATUS: nxt_rdata = {29'h00000000, link_pend_ff, arm_ff};
        default: nxt_rdata = npsr_pkg::UNMAPPED_RD;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      sync_ctrl_ff <= npsr_pkg::SYNC_CTRL_RST;
      freq_ff <= npsr_pkg::FREQ_A0_RST;
      phase_ff <= npsr_pkg::PHASE_A0_RST;
      link_ctrl_ff <= 8'h00;
      arm_wr_ff <= 1'b0;
      arm_val_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      sync_ctrl_ff <= nxt_sync_ctrl;
      freq_ff <= nxt_freq;
      phase_ff <= nxt_phase;
      link_ctrl_ff <= nxt_link_ctrl;
      arm_wr_ff <= nxt_arm_wr;
      arm_val_ff <= nxt_arm_val;
    end
  end

  always_comb begin
    AVS_WAITREQUEST = !ack_ff;
    AVS_READDATA = rdata_ff;
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, a change counts when stages 2 and 3 agree
  logic [2:0] sync_sh_ff, nxt_sync_sh;
  logic [2:0] sref_sh_ff, nxt_sref_sh;
  logic [2:0] fb_sh_ff, nxt_fb_sh;
  logic sync_lvl_ff, nxt_sync_lvl;
  logic sref_lvl_ff, nxt_sref_lvl;
  logic fb_lvl_ff, nxt_fb_lvl;
  logic sync_rise, sref_rise, fb_rise;

  always_comb begin
    nxt_sync_sh = {sync_sh_ff[1:0], SYNC_N};
    nxt_sref_sh = {sref_sh_ff[1:0], SYSREF};
    nxt_fb_sh = {fb_sh_ff[1:0], FRAME_BOUNDARY};
    nxt_sync_lvl = (sync_sh_ff[1] == sync_sh_ff[2]) ? sync_sh_ff[2] : sync_lvl_ff;
    nxt_sref_lvl = (sref_sh_ff[1] == sref_sh_ff[2]) ? sref_sh_ff[2] : sref_lvl_ff;
    nxt_fb_lvl = (fb_sh_ff[1] == fb_sh_ff[2]) ? fb_sh_ff[2] : fb_lvl_ff;
    sync_rise = nxt_sync_lvl && !sync_lvl_ff;
    sref_rise = nxt_sref_lvl && !sref_lvl_ff;
    fb_rise = nxt_fb_lvl && !fb_lvl_ff;
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      // sync~ idles high: start at that level so a reset with the link up leaves no false rise
      sync_sh_ff <= 3'h7;
      sref_sh_ff <= 3'h0;
      fb_sh_ff <= 3'h0;
      sync_lvl_ff <= 1'b1;
      sref_lvl_ff <= 1'b0;
      fb_lvl_ff <= 1'b0;
    end else begin
      sync_sh_ff <= nxt_sync_sh;
      sref_sh_ff <= nxt_sref_sh;
      fb_sh_ff <= nxt_fb_sh;
      sync_lvl_ff <= nxt_sync_lvl;
      sref_lvl_ff <= nxt_sref_lvl;
      fb_lvl_ff <= nxt_fb_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // phase-init triggers
  logic init_ff, nxt_init;
  logic link_req_ff, nxt_link_req;
  logic active_ff, nxt_active;
  npsr_pkg::npsr_osc_t osc_ff, nxt_osc;
  logic enc64;

  assign enc64 = link_ctrl_ff[npsr_pkg::POS_ENC_64];

  always_comb begin
    nxt_arm = arm_ff;
    nxt_link_pend = link_pend_ff;
    nxt_init = 1'b0;
    // arm only on a 0 write followed by a 1 write
    case (arm_ff)
      npsr_pkg::NPSR_IDLE, npsr_pkg::NPSR_DONE: begin
        if (arm_wr_ff && !arm_val_ff) begin
          nxt_arm = npsr_pkg::NPSR_SEEN0;
        end
      end
      npsr_pkg::NPSR_SEEN0: begin
        if (arm_wr_ff && arm_val_ff) begin
          nxt_arm = npsr_pkg::NPSR_ARMED;
        end
      end
      npsr_pkg::NPSR_ARMED: begin
        if (arm_wr_ff && !arm_val_ff) begin
          nxt_arm = npsr_pkg::NPSR_SEEN0;
        end else if (sref_rise) begin
          nxt_arm = npsr_pkg::NPSR_DONE;
          nxt_init = 1'b1;
        end
      end
      default: nxt_arm = npsr_pkg::NPSR_IDLE;
    endcase
    // sync rise waits for the next frame boundary; same logic for both encodings
    if (!sync_ctrl_ff[npsr_pkg::POS_LINK_INIT]) begin
      nxt_link_pend = 1'b0;
    end else if (sync_rise) begin
      nxt_link_pend = 1'b1;
    end else if (link_pend_ff && fb_rise) begin
      nxt_link_pend = 1'b0;
      nxt_init = 1'b1;
    end
    // 64b/66b: sync never reaches the link state machine
    nxt_link_req = enc64 ? 1'b0 : !nxt_sync_lvl;
    nxt_active = !link_ctrl_ff[npsr_pkg::POS_PRESET_CONTROL_MODE] &&
                 (link_ctrl_ff[npsr_pkg::POS_CSEL +: 2] == 2'h0);
    nxt_osc.freq = freq_ff;
    // left-justified, modular: signed and unsigned readings coincide
    nxt_osc.phase = {phase_ff, 16'h0000};
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      arm_ff <= npsr_pkg::NPSR_IDLE;
      link_pend_ff <= 1'b0;
      init_ff <= 1'b0;
      link_req_ff <= 1'b0;
      active_ff <= 1'b0;
      osc_ff <= '0;
    end else begin
      arm_ff <= nxt_arm;
      link_pend_ff <= nxt_link_pend;
      init_ff <= nxt_init;
      link_req_ff <= nxt_link_req;
      active_ff <= nxt_active;
      osc_ff <= nxt_osc;
    end
  end

  always_comb begin
    PHASE_INIT = init_ff;
    LINK_SYNC_REQ = link_req_ff;
    OSC_ACTIVE = active_ff;
    OSC_FREQ = osc_ff.freq;
    OSC_PHASE = osc_ff.phase;
  end

  //////////////////////////////////////////////////////////////////////////////
  armed_fire_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (arm_ff == npsr_pkg::NPSR_ARMED && sref_rise && !arm_wr_ff) |=> PHASE_INIT)
    else $error("armed sysref rise gave no phase init");
  oneshot_sref_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (arm_ff == npsr_pkg::NPSR_DONE && !sync_ctrl_ff[npsr_pkg::POS_LINK_INIT]) |=> !PHASE_INIT)
    else $error("phase init after one-shot without rearm");
  link_init_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (link_pend_ff && fb_rise && sync_ctrl_ff[npsr_pkg::POS_LINK_INIT] && !sync_rise)
    |=> PHASE_INIT)
    else $error("frame boundary after sync rise gave no init");
  enc_both_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (sync_rise && sync_ctrl_ff[npsr_pkg::POS_LINK_INIT]) |=> link_pend_ff)
    else $error("sync rise not taken in this encoding");
  sync_link_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    $past(enc64) |-> !LINK_SYNC_REQ)
    else $error("sync reached link in 64b/66b");
  freq_reset_a: assert property (@(posedge CLOCK)
    $rose(ARST_N) |-> freq_ff == npsr_pkg::FREQ_A0_RST)
    else $error("frequency word reset value wrong");
  phase_just_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    ##1 OSC_PHASE == {$past(phase_ff), 16'h0000})
    else $error("phase not left-justified");
  phase_low_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    OSC_PHASE[15:0] == 16'h0000)
    else $error("phase low bits not zero");
  preset_sel_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    ARST_N |=> OSC_ACTIVE == ($past(link_ctrl_ff[3:1]) == 3'h0))
    else $error("preset-0 active flag wrong");
  edge_once_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    sref_rise |=> !sref_rise)
    else $error("one sysref edge counted twice");
  same_phase_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    ##1 OSC_PHASE[31:16] == $past(phase_ff))
    else $error("phase bits altered by sign reading");
endmodule // npsr_regs
`default_nettype wire

// >>> npsr_pkg.sv
// package for the oscillator phase-sync and preset-0 register bank
`default_nettype none
package npsr_pkg;
  // printed offsets are not all multiples of four: they are indices, byte address = 4 * index
  localparam logic [11:0] IDX_SYNC_CTRL = 12'h219;
  localparam logic [11:0] IDX_FREQ_A0 = 12'h220;
  localparam logic [11:0] IDX_PHASE_A0 = 12'h224;
  localparam logic [11:0] IDX_LINK_CTRL = 12'h300;
  localparam logic [11:0] IDX_STATUS = 12'h301;
  localparam int ADDR_W = 14;
  localparam logic [7:0] SYNC_CTRL_RST = 8'h02;
  localparam logic [31:0] FREQ_A0_RST = 32'hc0000000;
  localparam logic [15:0] PHASE_A0_RST = 16'h0000;
  localparam int POS_LINK_INIT = 1;
  localparam int POS_ARM = 0;
  localparam int POS_ENC_64 = 0;
  localparam int POS_PRESET_CONTROL_MODE = 1;
  localparam int POS_CSEL = 2;
  localparam logic [31:0] UNMAPPED_RD = 32'h00000000;
  localparam int PHASE_W = 16;
  typedef struct packed {
    logic [31:0] freq;
    logic [31:0] phase;
  } npsr_osc_t;
  typedef enum logic [1:0] {
    NPSR_IDLE = 2'b00,
    NPSR_SEEN0 = 2'b01,
    NPSR_ARMED = 2'b11,
    NPSR_DONE = 2'b10
  } npsr_arm_t;
endpackage
`default_nettype wire

// >>> npsr_far_end.sv
// far-end model: link sync, frame boundary and sysref source
`default_nettype none
module npsr_far_end (
  input wire logic CLOCK,
  output var logic SYNC_N,
  output var logic SYSREF,
  output var logic FRAME_BOUNDARY
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    SYNC_N = 1'b0;
    SYSREF = 1'b0;
    FRAME_BOUNDARY = 1'b0;
  end
  // whole cycles only, so the pin synchroniser sees every level
  task automatic hold(input int sel, input logic v, input int n);
    @(posedge CLOCK);
    case (sel)
      0: SYNC_N <= v;
      1: SYSREF <= v;
      default: FRAME_BOUNDARY <= v;
    endcase
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic pulse(input int sel);
    hold(sel, 1'b1, 3);
    hold(sel, 1'b0, 3);
  endtask
endmodule // npsr_far_end
`default_nettype wire

// >>> nco_phase_sync_preset_regs_test.sv
// self-checking bench for the phase-sync and preset-0 register bank
`default_nettype none
module nco_phase_sync_preset_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK;
  logic ARST_N;
  logic [13:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic wait_rq;
  wire logic sync_n;
  wire logic sysref;
  wire logic frame;
  logic phase_init;
  logic osc_active;
  logic link_req;
  logic [31:0] osc_freq;
  logic [31:0] osc_phase;
  int compares = 0;
  int miscompares = 0;
  int pulses = 0;
  int base = 0;
  npsr_regs i_dut (.CLOCK(CLOCK), .ARST_N(ARST_N), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_rq), .SYNC_N(sync_n), .SYSREF(sysref), .FRAME_BOUNDARY(frame),
    .PHASE_INIT(phase_init), .OSC_ACTIVE(osc_active), .OSC_FREQ(osc_freq),
    .OSC_PHASE(osc_phase), .LINK_SYNC_REQ(link_req));
  npsr_far_end far (.CLOCK(CLOCK), .SYNC_N(sync_n), .SYSREF(sysref), .FRAME_BOUNDARY(frame));
  always @(posedge CLOCK) begin
    if (phase_init === 1'b1) pulses <= pulses + 1;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge CLOCK);
    rd <= !w;
    wr <= w;
    addr <= {idx, 2'b00};
    wdata <= d;
    do begin
      @(posedge CLOCK);
      n++;
    end while (wait_rq !== 1'b0 && n < 50);
    q = rdata;
    if (n >= 50) miscompares++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rchk(input string nm, input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h00000000, q);
    chk(nm, q, exp);
  endtask
  task automatic settle(input string nm, input int n);
    repeat (10) @(posedge CLOCK);
    chk(nm, pulses - base, n);
    base = pulses;
  endtask
  task automatic t_reset();
    rchk("sync_ctrl", npsr_pkg::IDX_SYNC_CTRL, 32'h00000002);
    rchk("freq_rst", npsr_pkg::IDX_FREQ_A0, 32'hc0000000);
    rchk("phase_rst", npsr_pkg::IDX_PHASE_A0, 32'h00000000);
    rchk("unmapped", 12'h3ff, 32'h00000000);
    chk("active", osc_active, 32'h00000001);
    chk("osc_freq", osc_freq, 32'hc0000000);
  endtask
  task automatic t_regs();
    wreg(npsr_pkg::IDX_FREQ_A0, 32'h12345678);
    wreg(npsr_pkg::IDX_PHASE_A0, 32'habcd8001);
    rchk("freq_rw", npsr_pkg::IDX_FREQ_A0, 32'h12345678);
    rchk("phase_rw", npsr_pkg::IDX_PHASE_A0, 32'h00008001);
    be <= 4'h2;
    wreg(npsr_pkg::IDX_FREQ_A0, 32'hffffffff);
    be <= 4'hf;
    rchk("freq_lane", npsr_pkg::IDX_FREQ_A0, 32'h1234ff78);
    repeat (2) @(posedge CLOCK);
    chk("osc_freq", osc_freq, 32'h1234ff78);
    chk("osc_phase", osc_phase, 32'h80010000);
  endtask
  // sync rise arms, the next frame boundary fires exactly once
  task automatic t_sync(input logic [31:0] enc);
    wreg(npsr_pkg::IDX_LINK_CTRL, enc);
    far.hold(0, 1'b0, 6);
    chk("link_req", link_req, {31'h0, !enc[0]});
    base = pulses;
    far.hold(0, 1'b1, 6);
    settle("no_boundary", 0);
    far.pulse(2);
    settle("sync_init", 1);
    far.pulse(2);
    settle("stale_sync", 0);
  endtask
  task automatic t_arm();
    wreg(npsr_pkg::IDX_SYNC_CTRL, 32'h00000001);
    base = pulses;
    far.pulse(1);
    settle("no_zero_first", 0);
    wreg(npsr_pkg::IDX_SYNC_CTRL, 32'h00000000);
    wreg(npsr_pkg::IDX_SYNC_CTRL, 32'h00000001);
    rchk("armed_state", npsr_pkg::IDX_STATUS, 32'h00000003);
    far.pulse(1);
    settle("armed", 1);
    far.pulse(1);
    settle("fired_once", 0);
    rchk("fired_state", npsr_pkg::IDX_STATUS, 32'h00000002);
    wreg(npsr_pkg::IDX_SYNC_CTRL, 32'h00000000);
    wreg(npsr_pkg::IDX_SYNC_CTRL, 32'h00000001);
    far.pulse(1);
    settle("rearmed", 1);
  endtask
  task automatic t_mode();
    wreg(npsr_pkg::IDX_LINK_CTRL, 32'h00000002);
    repeat (2) @(posedge CLOCK);
    chk("mode_off", osc_active, 32'h00000000);
    wreg(npsr_pkg::IDX_LINK_CTRL, 32'h00000004);
    repeat (2) @(posedge CLOCK);
    chk("sel_one", osc_active, 32'h00000000);
    wreg(npsr_pkg::IDX_LINK_CTRL, 32'h00000000);
    repeat (2) @(posedge CLOCK);
    chk("sel_zero", osc_active, 32'h00000001);
  endtask
  // mid-run reset while sync~ is high must leave no false sync rise behind
  task automatic t_rst2();
    wreg(npsr_pkg::IDX_FREQ_A0, 32'h0badf00d);
    ARST_N <= 1'b0;
    repeat (3) @(posedge CLOCK);
    ARST_N <= 1'b1;
    rchk("freq_rst2", npsr_pkg::IDX_FREQ_A0, 32'hc0000000);
    rchk("sync_rst2", npsr_pkg::IDX_SYNC_CTRL, 32'h00000002);
    base = pulses;
    far.pulse(2);
    settle("no_false_sync", 0);
  endtask
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  initial begin
    #200us;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    ARST_N = 1'b0;
    addr = 14'h0000;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h00000000;
    be = 4'hf;
    repeat (3) @(posedge CLOCK);
    ARST_N <= 1'b1;
    t_reset();
    t_regs();
    t_sync(32'h00000000);
    t_sync(32'h00000001);
    t_arm();
    t_mode();
    t_rst2();
    tally_and_finish();
  end
endmodule // nco_phase_sync_preset_regs_test
`default_nettype wire
